// >>> src/mlctp_pkg.sv
// Constants, register map and state types for the modem line control and
// transmit pointer block. Assumes one 10 MHz clock and an active-low reset.
// Summary of operation
// - Enabled line shows status, transitions flag scan
// - Bit 01 holds terminal ready asserted
// - Bit 02 asserts request to send
// - Bit 03 drives resync or reverse transmit
// - Bits 00-03 cleared by reset, clear-mux
// - Bit 05 shows clear-to-send when enabled
// - Bit 06 shows carrier detect when enabled
// - Bit 07 shows ring indicator when enabled
// - 256-word secondary RAM, indirect select/access
// - Reset leaves secondary RAM untouched
// - Current address 18 bits, high from system
// - Address increments per character on principal table
// - Count zero posts DMA status code
// - Continue on alternate address if go set
// - Count is 15-bit two's complement, increments
// - Unmarked count takes progress mode, block check
// - Marked count keeps transmit mode field
// - Zero count with go switches to alternate
// - Scan transition sets done, records line
package mlctp_pkg;
  localparam int NUM_LINES = 16;
  localparam int ADDR_W = 18;

  // Host register port addresses
  localparam logic [2:0] ADR_CTRL = 3'h0;
  localparam logic [2:0] ADR_LINESTAT = 3'h1;
  localparam logic [2:0] ADR_SYSCTL = 3'h2;
  localparam logic [2:0] ADR_SELECT = 3'h3;
  localparam logic [2:0] ADR_ACCESS = 3'h4;
  localparam logic [2:0] ADR_DMASTAT = 3'h5;

  // Main control register fields
  localparam int CT_SCANEN = 5;
  localparam int CT_DONE = 7;
  localparam int CT_CLRMUX = 10;
  localparam int CT_CLRSCAN = 11;
  localparam int CT_TRANS_LO = 12;

  // Line status control bit positions
  localparam int LS_ENABLE = 0;
  localparam int LS_TERMRDY = 1;
  localparam int LS_RTS = 2;
  localparam int LS_RESYNC = 3;

  // System control fields
  localparam int SC_EXT_LO = 4;

  // Secondary register indices
  localparam logic [3:0] SR_TX_ADDR = 4'h0;
  localparam logic [3:0] SR_TX_CNT = 4'h1;
  localparam logic [3:0] SR_LINE_STATE = 4'hB;
  localparam logic [3:0] SR_TX_MODE = 4'hC;
  localparam logic [3:0] SR_LINE_PROG = 4'hE;

  // Secondary register fields
  localparam int ST_ALT_TABLE = 7;
  localparam int ST_TX_GO = 0;
  localparam int CNT_MARK = 15;
  localparam int PG_MODE_LO = 13;
  localparam int PG_BLOCK_CHECK = 10;

  // DMA status layout: valid, code, line
  localparam int DS_VALID = 15;
  localparam logic [3:0] DS_CODE_TX_PRIN = 4'h1;

  typedef enum logic [1:0] {
    MLCTP_TX_IDLE = 2'h0,
    MLCTP_TX_ADDR = 2'h1,
    MLCTP_TX_CNT = 2'h3,
    MLCTP_TX_ZERO = 2'h2
  } mlctp_tx_t;

  typedef struct packed {
    logic [3:0] lineSel;
    logic scanEn;
    logic done;
    logic [3:0] trans;
    logic clrScan;
    logic [NUM_LINES-1:0][3:0] ctl;
    logic [15:0] sysCtl;
    logic [7:0] select;
    logic [15:0] dma;
    logic [15:0] rdata;
    logic [NUM_LINES-1:0] termRdy;
    logic [NUM_LINES-1:0] rts;
    logic [NUM_LINES-1:0] resync;
    logic [NUM_LINES-1:0] revTx;
    mlctp_tx_t tx;
    logic [3:0] txLine;
    logic [2:0] txMode;
    logic modeStrobe;
    logic blockCheck;
  } mlctp_state_t;
endpackage

// >>> src/mlctp_scan_if.sv
// Scan report group between the top and the modem scanner.
// Assumes both ends share clk.
`timescale 1ns/1ps
`default_nettype none
interface mlctp_scan_if;
  logic scanEn;
  logic clrScan;
  logic hold;
  logic hit;
  logic [3:0] hitLine;
  logic [3:0] hitDiff;
  modport ctrl(output scanEn, output clrScan, output hold,
               input hit, input hitLine, input hitDiff);
  modport scanner(input scanEn, input clrScan, input hold,
                  output hit, output hitLine, output hitDiff);
endinterface
`default_nettype wire

// >>> src/mlctp_sync.sv
// Two-stage synchroniser for a bus of independent level signals.
// Assumes each bit is a slow level; bits are not coherent as a word.
`timescale 1ns/1ps
`default_nettype none
module mlctp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mlctp_sync_t;
  mlctp_sync_t st_reg, st_next;

  always_comb begin
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.s2;
endmodule
`default_nettype wire

// >>> src/mlctp_scan.sv
// Modem scanner: walks the lines, compares status with scan memory.
// Assumes status is already synchronised; order per line is
// {ring, carrier, clear-to-send, data-set-ready}.
`timescale 1ns/1ps
`default_nettype none
module mlctp_scan
  import mlctp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Modem side
  input wire logic [NUM_LINES-1:0][3:0] status,
  input wire logic [NUM_LINES-1:0] lineEnable,
  // Report
  mlctp_scan_if.scanner sc
);
  typedef struct packed {
    logic [3:0] ptr;
    logic [NUM_LINES-1:0][3:0] mem;
    logic hit;
    logic [3:0] hitLine;
    logic [3:0] hitDiff;
  } mlctp_scan_t;
  mlctp_scan_t st_reg, st_next;
  logic [3:0] cur;
  logic [3:0] diff;

  always_comb begin
    st_next = st_reg;
    st_next.hit = 1'b0;
    cur = status[st_reg.ptr];
    diff = cur ^ st_reg.mem[st_reg.ptr];
    // Ring only reports the off-to-on edge
    diff[3] = diff[3] & cur[3];
    if (sc.clrScan) begin
      // Cleared memory makes every ON input look like a fresh edge
      st_next.mem = '0;
      st_next.ptr = '0;
    end else if (sc.scanEn && !sc.hold && !st_reg.hit) begin
      st_next.mem[st_reg.ptr] = cur;
      st_next.ptr = st_reg.ptr + 4'h1;
      if (lineEnable[st_reg.ptr] && diff != 4'h0) begin
        st_next.hit = 1'b1;
        st_next.hitLine = st_reg.ptr;
        st_next.hitDiff = diff;
        st_next.ptr = st_reg.ptr;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sc.hit = st_reg.hit;
  assign sc.hitLine = st_reg.hitLine;
  assign sc.hitDiff = st_reg.hitDiff;
endmodule
`default_nettype wire

// >>> src/mlctp_top.sv
// Modem line control and transmit principal pointer logic for 16 lines.
// Assumes a host register port on clk, modem pins from outside the clock
// domain, and a character-sent strobe from transmit logic on clk.
`timescale 1ns/1ps
`default_nettype none
module mlctp_top
  import mlctp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host register port
  input wire logic [2:0] hostAddr,
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [15:0] hostWdata,
  output logic [15:0] hostRdata,
  // Modem status pins
  input wire logic [mlctp_pkg::NUM_LINES-1:0] dataSetReadyIn,
  input wire logic [mlctp_pkg::NUM_LINES-1:0] clearToSendIn,
  input wire logic [mlctp_pkg::NUM_LINES-1:0] carrier_detect_in,
  input wire logic [mlctp_pkg::NUM_LINES-1:0] ringIn,
  input wire logic [mlctp_pkg::NUM_LINES-1:0] modemAsync,
  // Modem control pins
  output logic [mlctp_pkg::NUM_LINES-1:0] terminalReadyOut,
  output logic [mlctp_pkg::NUM_LINES-1:0] request_to_send_out,
  output logic [mlctp_pkg::NUM_LINES-1:0] carrier_resync_out,
  output logic [mlctp_pkg::NUM_LINES-1:0] reverse_channel_transmit,
  // Transmit events
  input wire logic txCharSent,
  input wire logic [3:0] txCharLine,
  output logic [15:0] dma_status,
  output logic [2:0] txModeOut,
  output logic txModeStrobe,
  output logic block_check_request,
  output logic [15:0] sysControlOut
);
  import mlctp_pkg::*;

  mlctp_state_t st_reg, st_next;

  // Secondary RAM: no reset, contents survive initialise
  logic [ADDR_W-1:0] secRam [0:255];
  logic ramWe;
  logic [7:0] ramWaddr;
  logic [ADDR_W-1:0] ramWdata;

  logic [NUM_LINES-1:0][3:0] modemRaw;
  logic [NUM_LINES-1:0][3:0] modemSync;
  logic [NUM_LINES-1:0] lineEnable;
  logic [NUM_LINES-1:0] asyncSync;
  mlctp_scan_if scanBus ();

  logic [3:0] selCtl;
  logic [3:0] selStat;
  logic hostWrAccess;
  logic [7:0] hostRamAddr;
  logic [ADDR_W-1:0] hostRamRd;
  logic [ADDR_W-1:0] txAddrWord;
  logic [ADDR_W-1:0] txCntWord;
  logic [ADDR_W-1:0] txStateWord;
  logic [ADDR_W-1:0] txProgWord;
  logic [ADDR_W-1:0] txModeWord;
  logic [ADDR_W-1:0] evStateWord;
  logic [14:0] cntNext;

  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      modemRaw[i] = {ringIn[i], carrier_detect_in[i], clearToSendIn[i],
                     dataSetReadyIn[i]};
      lineEnable[i] = st_reg.ctl[i][LS_ENABLE];
    end
  end

  mlctp_sync #(
    .W(NUM_LINES * 4)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din(modemRaw),
    .dout(modemSync)
  );

  // Modem type strap is a pin too, so it is synchronised like the status
  mlctp_sync #(
    .W(NUM_LINES)
  ) u_sync_mode (
    .clk(clk),
    .reset_n(reset_n),
    .din(modemAsync),
    .dout(asyncSync)
  );

  mlctp_scan u_scan (
    .clk(clk),
    .reset_n(reset_n),
    .status(modemSync),
    .lineEnable(lineEnable),
    .sc(scanBus)
  );

  assign scanBus.scanEn = st_reg.scanEn;
  assign scanBus.clrScan = st_reg.clrScan;
  assign scanBus.hold = st_reg.done;

  // Host indirect path and engine read taps
  assign hostRamAddr = {st_reg.select[7:4], st_reg.select[3:0]};
  assign hostRamRd = secRam[hostRamAddr];
  assign txAddrWord = secRam[{st_reg.txLine, SR_TX_ADDR}];
  assign txCntWord = secRam[{st_reg.txLine, SR_TX_CNT}];
  assign txStateWord = secRam[{st_reg.txLine, SR_LINE_STATE}];
  assign txProgWord = secRam[{st_reg.txLine, SR_LINE_PROG}];
  assign txModeWord = secRam[{st_reg.txLine, SR_TX_MODE}];
  assign evStateWord = secRam[{txCharLine, SR_LINE_STATE}];
  assign cntNext = txCntWord[14:0] + 15'h0001;
  assign hostWrAccess = hostWrite && (hostAddr == ADR_ACCESS);

  assign selCtl = st_reg.ctl[st_reg.lineSel];
  // Status shows only for an enabled line
  assign selStat = selCtl[LS_ENABLE] ? modemSync[st_reg.lineSel]
                                     : 4'h0;

  always_comb begin
    st_next = st_reg;
    st_next.clrScan = 1'b0;
    st_next.modeStrobe = 1'b0;
    st_next.blockCheck = 1'b0;
    ramWe = 1'b0;
    ramWaddr = hostRamAddr;
    ramWdata = {2'h0, hostWdata};

    // Host writes
    if (hostWrite) begin
      case (hostAddr)
        ADR_CTRL: begin
          st_next.lineSel = hostWdata[3:0];
          st_next.scanEn = hostWdata[CT_SCANEN];
          st_next.done = hostWdata[CT_DONE];
          if (hostWdata[CT_CLRMUX]) begin
            st_next.ctl = '0;
          end
          if (hostWdata[CT_CLRSCAN]) begin
            st_next.lineSel = 4'h0;
            st_next.scanEn = 1'b0;
            st_next.done = 1'b0;
            st_next.trans = 4'h0;
            st_next.clrScan = 1'b1;
          end
        end
        ADR_LINESTAT: begin
          // Upper bits come only from the modem pins
          st_next.ctl[st_reg.lineSel] = hostWdata[3:0];
        end
        ADR_SYSCTL: begin
          st_next.sysCtl = hostWdata;
        end
        ADR_SELECT: begin
          st_next.select = hostWdata[7:0];
        end
        ADR_ACCESS: begin
          ramWe = 1'b1;
          if (st_reg.select[3:0] == SR_TX_ADDR) begin
            ramWdata = {st_reg.sysCtl[SC_EXT_LO +: 2], hostWdata};
          end
        end
        default: begin
        end
      endcase
    end

    // Scan hit: set wins over a host clear in the same cycle
    if (scanBus.hit) begin
      st_next.done = 1'b1;
      st_next.lineSel = scanBus.hitLine;
      st_next.trans = st_reg.trans | scanBus.hitDiff;
    end

    // Host reads: answer registered one cycle later
    if (hostRead) begin
      case (hostAddr)
        ADR_CTRL: begin
          st_next.rdata = {st_reg.trans, 4'h0, st_reg.done, 1'b0,
                           st_reg.scanEn, 1'b0, st_reg.lineSel};
        end
        ADR_LINESTAT: begin
          st_next.rdata = {8'h00, selStat, selCtl};
        end
        ADR_SYSCTL: begin
          st_next.rdata = st_reg.sysCtl;
        end
        ADR_SELECT: begin
          st_next.rdata = {8'h00, st_reg.select};
        end
        ADR_ACCESS: begin
          st_next.rdata = hostRamRd[15:0];
        end
        ADR_DMASTAT: begin
          st_next.rdata = st_reg.dma;
          st_next.dma[DS_VALID] = 1'b0;
        end
        default: begin
          st_next.rdata = 16'h0000;
        end
      endcase
    end

    // Transmit principal pointer engine; host RAM writes take the port
    // first, so the engine simply waits a cycle on a collision.
    case (st_reg.tx)
      MLCTP_TX_IDLE: begin
        // Events while busy or on the alternate table are not handled here
        if (txCharSent && !evStateWord[ST_ALT_TABLE]) begin
          st_next.txLine = txCharLine;
          st_next.tx = MLCTP_TX_ADDR;
        end
      end
      MLCTP_TX_ADDR: begin
        if (!hostWrAccess) begin
          ramWe = 1'b1;
          ramWaddr = {st_reg.txLine, SR_TX_ADDR};
          ramWdata = txAddrWord + 18'h00001;
          st_next.tx = MLCTP_TX_CNT;
        end
      end
      MLCTP_TX_CNT: begin
        if (!hostWrAccess) begin
          ramWe = 1'b1;
          ramWaddr = {st_reg.txLine, SR_TX_CNT};
          ramWdata = {txCntWord[ADDR_W-1:CNT_MARK], cntNext};
          st_next.tx = (cntNext == 15'h0000) ? MLCTP_TX_ZERO
                                              : MLCTP_TX_IDLE;
        end
      end
      MLCTP_TX_ZERO: begin
        if (!hostWrAccess) begin
          st_next.dma = {1'b1, 3'h0, 4'h0, DS_CODE_TX_PRIN,
                         st_reg.txLine};
          st_next.modeStrobe = 1'b1;
          if (!txCntWord[CNT_MARK]) begin
            st_next.txMode = txProgWord[PG_MODE_LO +: 3];
            st_next.blockCheck = txProgWord[PG_BLOCK_CHECK];
          end else begin
            st_next.txMode = txModeWord[2:0];
          end
          if (txStateWord[ST_TX_GO]) begin
            // Next characters use alternate address and count
            ramWe = 1'b1;
            ramWaddr = {st_reg.txLine, SR_LINE_STATE};
            ramWdata = txStateWord;
            ramWdata[ST_ALT_TABLE] = 1'b1;
          end
          st_next.tx = MLCTP_TX_IDLE;
        end
      end
      default: begin
        st_next.tx = MLCTP_TX_IDLE;
      end
    endcase

    // Modem outputs follow the stored control bits
    for (int i = 0; i < NUM_LINES; i++) begin
      st_next.termRdy[i] = st_next.ctl[i][LS_TERMRDY];
      st_next.rts[i] = st_next.ctl[i][LS_RTS];
      st_next.resync[i] = st_next.ctl[i][LS_RESYNC] & ~asyncSync[i];
      st_next.revTx[i] = st_next.ctl[i][LS_RESYNC] & asyncSync[i];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // No reset on the RAM so contents live through initialise
  always_ff @(posedge clk) begin
    if (ramWe) begin
      secRam[ramWaddr] <= ramWdata;
    end
  end

  assign hostRdata = st_reg.rdata;
  assign terminalReadyOut = st_reg.termRdy;
  assign request_to_send_out = st_reg.rts;
  assign carrier_resync_out = st_reg.resync;
  assign reverse_channel_transmit = st_reg.revTx;
  assign dma_status = st_reg.dma;
  assign txModeOut = st_reg.txMode;
  assign txModeStrobe = st_reg.modeStrobe;
  assign block_check_request = st_reg.blockCheck;
  assign sysControlOut = st_reg.sysCtl;
endmodule
`default_nettype wire

// >>> bench/mlctp_props.sv
// Checker for line control outputs, status reads and transmit events.
// Assumes the scanner never moves the line field while a read is checked.
`timescale 1ns/1ps
`default_nettype none
module mlctp_props
  import mlctp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host port
  input wire logic [2:0] hostAddr,
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [15:0] hostWdata,
  input wire logic [15:0] hostRdata,
  // Modem pins
  input wire logic [NUM_LINES-1:0] modemAsync,
  input wire logic [NUM_LINES-1:0] terminalReadyOut,
  input wire logic [NUM_LINES-1:0] request_to_send_out,
  input wire logic [NUM_LINES-1:0] carrier_resync_out,
  input wire logic [NUM_LINES-1:0] reverse_channel_transmit,
  // Transmit events
  input wire logic [15:0] dma_status,
  input wire logic txModeStrobe,
  input wire logic block_check_request
);
  logic [3:0] selLine;
  logic [NUM_LINES-1:0][3:0] ctlTrk;
  logic [1:0] age;
  logic lsWr;
  assign lsWr = hostWrite && hostAddr == ADR_LINESTAT;
  // Age lets the outputs settle before they are compared
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selLine <= 4'h0;
      ctlTrk <= '0;
      age <= 2'h0;
    end else begin
      age <= (hostWrite && hostAddr <= ADR_LINESTAT) ? 2'h0 :
             (age == 2'h3) ? 2'h3 : age + 2'h1;
      if (hostWrite && hostAddr == ADR_CTRL) begin
        selLine <= hostWdata[3:0];
        if (hostWdata[CT_CLRMUX]) ctlTrk <= '0;
      end else if (lsWr) begin
        ctlTrk[selLine] <= hostWdata[3:0];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  term_ready_a:
    assert property (age == 2'h3 |->
      terminalReadyOut[selLine] == ctlTrk[selLine][LS_TERMRDY])
    else $error("terminal ready differs from stored bit");
  req_send_a:
    assert property (age == 2'h3 |->
      request_to_send_out[selLine] == ctlTrk[selLine][LS_RTS])
    else $error("request to send differs from stored bit");
  resync_out_a:
    assert property (age == 2'h3 && !modemAsync[selLine] |->
      carrier_resync_out[selLine] == ctlTrk[selLine][LS_RESYNC])
    else $error("resync output differs from stored bit");
  rev_tx_a:
    assert property (age == 2'h3 && modemAsync[selLine] |->
      reverse_channel_transmit[selLine] == ctlTrk[selLine][LS_RESYNC])
    else $error("reverse transmit differs from stored bit");
  clear_mux_a:
    assert property (hostWrite && hostAddr == ADR_CTRL &&
      hostWdata[CT_CLRMUX] |-> ##2
      (terminalReadyOut | request_to_send_out) == 16'h0000)
    else $error("clear mux left a control output high");
  ctl_readback_a:
    assert property (hostRead && hostAddr == ADR_LINESTAT |=>
      hostRdata[3:0] == $past(ctlTrk[selLine]))
    else $error("line control readback wrong");
  status_masked_a:
    assert property (hostRead && hostAddr == ADR_LINESTAT &&
      !ctlTrk[selLine][LS_ENABLE] |=> hostRdata[7:4] == 4'h0)
    else $error("status shown for disabled line");
  dma_code_a:
    assert property ($rose(dma_status[DS_VALID]) |->
      dma_status[7:4] == DS_CODE_TX_PRIN)
    else $error("wrong dma status code");
  mode_pulse_a:
    assert property (txModeStrobe |=> !txModeStrobe)
    else $error("mode strobe longer than one cycle");
  blk_check_a:
    assert property (block_check_request |->
      dma_status[DS_VALID] || $past(dma_status[DS_VALID]))
    else $error("block check without count zero");
  cover property (lsWr ##1 hostRead);
  cover property ($rose(dma_status[DS_VALID]));
  cover property (block_check_request);
  cover property (txModeStrobe);
endmodule
bind mlctp_top mlctp_props i_mlctp_props (.*);
`default_nettype wire

// >>> bench/mlctp_modem_model.sv
// Modem bank: data set ready follows terminal ready, clear to send
// answers request to send after DLY cycles. DLY must be 2 or more.
`timescale 1ns/1ps
`default_nettype none
module mlctp_modem_model #(
  parameter int DLY = 3
) (
  // Clock
  input wire logic clk,
  // From device
  input wire logic [15:0] terminalReadyOut,
  input wire logic [15:0] request_to_send_out,
  // To device
  output logic [15:0] dataSetReadyIn,
  output logic [15:0] clearToSendIn
);
  logic [DLY-1:0][15:0] rtsPipe = '0;
  always @(posedge clk) begin
    rtsPipe <= {rtsPipe[DLY-2:0], request_to_send_out};
  end
  assign clearToSendIn = rtsPipe[DLY-1];
  assign dataSetReadyIn = terminalReadyOut;
endmodule
`default_nettype wire

// >>> bench/mlctp_top_tb.sv
// Self-checking bench: host register tasks, modem model, char events.
// Assumes the checker is bound through its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin \
  errorCnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); \
  end end
module mlctp_top_tb;
  import mlctp_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] hostAddr = 3'h0;
  logic hostWrite = 1'b0;
  logic hostRead = 1'b0;
  logic [15:0] hostWdata = 16'h0000;
  logic [15:0] carrier = 16'h8029;
  logic [15:0] ring = 16'h8000;
  logic [15:0] async = 16'h0020;
  logic txCharSent = 1'b0;
  logic [3:0] txCharLine = 4'h0;
  logic [15:0] hostRdata, dsr, cts, trOut, rtsOut, resyncOut, revOut;
  logic [15:0] dmaStat, sysOut, expv;
  logic [2:0] txModeOut;
  logic strobe, blkReq;
  logic [3:0] strobeCnt = 4'h0;
  logic [3:0] blkCnt = 4'h0;
  logic [3:0] ln;
  logic [3:0] lines [3] = '{4'h0, 4'h5, 4'hF};
  int errorCnt = 0;
  int nChecks = 0;
  int cyc = 0;
  mlctp_top i_mlctp_top (.clk(clk), .reset_n(reset_n),
    .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
    .hostWdata(hostWdata), .hostRdata(hostRdata),
    .dataSetReadyIn(dsr), .clearToSendIn(cts),
    .carrier_detect_in(carrier), .ringIn(ring), .modemAsync(async),
    .terminalReadyOut(trOut), .request_to_send_out(rtsOut),
    .carrier_resync_out(resyncOut), .reverse_channel_transmit(revOut),
    .txCharSent(txCharSent), .txCharLine(txCharLine),
    .dma_status(dmaStat), .txModeOut(txModeOut),
    .txModeStrobe(strobe), .block_check_request(blkReq),
    .sysControlOut(sysOut));
  mlctp_modem_model i_mlctp_modem_model (.clk(clk),
    .terminalReadyOut(trOut), .request_to_send_out(rtsOut),
    .dataSetReadyIn(dsr), .clearToSendIn(cts));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (strobe === 1'b1) strobeCnt <= strobeCnt + 4'h1;
    if (blkReq === 1'b1) blkCnt <= blkCnt + 4'h1;
    if (cyc == 5000) begin
      errorCnt++;
      printVerdict();
    end
  end
  task automatic printVerdict();
    if (errorCnt == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk);
    hostAddr = a;
    hostWdata = d;
    hostWrite = 1'b1;
    @(negedge clk);
    hostWrite = 1'b0;
  endtask
  task automatic rdChk(input logic [2:0] a, input logic [15:0] e);
    @(negedge clk);
    hostAddr = a;
    hostRead = 1'b1;
    @(negedge clk);
    hostRead = 1'b0;
    @(negedge clk);
    `CHK(hostRdata, e)
  endtask
  task automatic secWr(input logic [3:0] l, i, input logic [15:0] d);
    wr(ADR_SELECT, {8'h00, l, i});
    wr(ADR_ACCESS, d);
  endtask
  task automatic secChk(input logic [3:0] l, i, input logic [15:0] e);
    wr(ADR_SELECT, {8'h00, l, i});
    rdChk(ADR_ACCESS, e);
  endtask
  // Engine is busy a few cycles after each event, so wait it out
  task automatic sendChar(input logic [3:0] l);
    @(negedge clk);
    txCharSent = 1'b1;
    txCharLine = l;
    @(negedge clk);
    txCharSent = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    `CHK({trOut, rtsOut, dmaStat}, 48'h0)
    for (int k = 0; k < 3; k++) begin
      ln = lines[k];
      wr(ADR_CTRL, {12'h000, ln});
      wr(ADR_LINESTAT, 16'h00FF);
      repeat (8) @(negedge clk);
      `CHK({trOut[ln], rtsOut[ln]}, 2'b11)
      `CHK({resyncOut[ln], revOut[ln]}, {!async[ln], async[ln]})
      expv = {8'h00, ring[ln], carrier[ln], 6'h3F};
      rdChk(ADR_LINESTAT, expv);
    end
    wr(ADR_CTRL, 16'h0003);
    wr(ADR_LINESTAT, 16'h0006);
    repeat (8) @(negedge clk);
    rdChk(ADR_LINESTAT, 16'h0006);
    wr(ADR_CTRL, 16'h0000);
    rdChk(ADR_LINESTAT, 16'h007F);
    wr(ADR_CTRL, 16'h0400);
    `CHK({trOut, rtsOut}, 32'h0)
    rdChk(ADR_LINESTAT, 16'h0000);
    // Cleared scan memory makes the ON inputs of line 15 look new
    wr(ADR_CTRL, 16'h000F);
    wr(ADR_LINESTAT, 16'h0001);
    wr(ADR_CTRL, 16'h0800);
    wr(ADR_CTRL, 16'h0020);
    repeat (100) @(negedge clk);
    rdChk(ADR_CTRL, 16'hC0AF);
    wr(ADR_CTRL, 16'h0800);
    wr(ADR_SYSCTL, 16'h0020);
    `CHK(sysOut, 16'h0020)
    secWr(4'h2, SR_TX_ADDR, 16'h1234);
    secWr(4'h2, SR_TX_CNT, 16'hFFFE);
    secWr(4'h2, SR_LINE_PROG, 16'h0400);
    secWr(4'h2, SR_TX_MODE, 16'h0002);
    secWr(4'h2, SR_LINE_STATE, 16'h0001);
    wr(ADR_SYSCTL, 16'h0021);
    `CHK(sysOut, 16'h0021)
    sendChar(4'h2);
    secChk(4'h2, SR_TX_ADDR, 16'h1235);
    secChk(4'h2, SR_TX_CNT, 16'hFFFF);
    `CHK(dmaStat, 16'h0000)
    sendChar(4'h2);
    secChk(4'h2, SR_TX_CNT, 16'h8000);
    `CHK(dmaStat, 16'h8012)
    `CHK({strobeCnt, blkCnt, txModeOut}, {4'h1, 4'h0, 3'h2})
    secChk(4'h2, SR_LINE_STATE, 16'h0081);
    sendChar(4'h2);
    secChk(4'h2, SR_TX_ADDR, 16'h1236);
    rdChk(ADR_DMASTAT, 16'h8012);
    `CHK(dmaStat[DS_VALID], 1'b0)
    secWr(4'h3, SR_TX_ADDR, 16'h0000);
    secWr(4'h3, SR_TX_CNT, 16'h7FFF);
    secWr(4'h3, SR_LINE_PROG, 16'hA400);
    secWr(4'h3, SR_LINE_STATE, 16'h0000);
    sendChar(4'h3);
    `CHK({strobeCnt, blkCnt, txModeOut}, {4'h2, 4'h1, 3'h5})
    `CHK(dmaStat, 16'h8013)
    secChk(4'h3, SR_LINE_STATE, 16'h0000);
    @(negedge clk);
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    secChk(4'h2, SR_TX_ADDR, 16'h1236);
    `CHK(dmaStat, 16'h0000)
    printVerdict();
  end
endmodule
`default_nettype wire
